// File: tft_panel_timing_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tft_panel_timing_generator_tb;
  logic        clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pixel_req;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
  logic [23:0] pixel_in = 24'h00_0000, line_data;
  logic        pixel_clock, line_sync, frame_sync, data_valid_strobe;
  logic        mdl_rst_n = 0, m_inv = 0;
  logic [1:0]  m_pol = 2'h0;
  logic [3:0]  m_lag = 4'h0;
  int          pmin, pmax, line_len, hs_w, de_ofs, de_cnt, frame_len, vs_w, errs;
  int          err_count = 0, n_tests = 0, cyc_cnt = 0;
  logic [31:0] rst_tab[6];

  always #2 clock = ~clock;

  ttg_timing_gen ttg_timing_gen_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pixel_in(pixel_in), .pixel_req(pixel_req), .pixel_clock(pixel_clock),
    .line_sync(line_sync), .frame_sync(frame_sync),
    .data_valid_strobe(data_valid_strobe), .line_data(line_data));

  ttg_panel_model ttg_panel_model_inst (.clock(clock), .rst_n(mdl_rst_n),
    .pixel_clock(pixel_clock), .line_sync(line_sync), .frame_sync(frame_sync),
    .data_valid_strobe(data_valid_strobe), .line_data(line_data), .pixel_req(pixel_req),
    .pixel_in(pixel_in), .pol(m_pol), .inv(m_inv), .lag(m_lag), .pmin(pmin), .pmax(pmax),
    .line_len(line_len), .hs_w(hs_w), .de_ofs(de_ofs), .de_cnt(de_cnt),
    .frame_len(frame_len), .vs_w(vs_w), .errs(errs));

  // fresh pixel value after each one taken
  always @(posedge clock)
    if (pixel_req === 1'b1) pixel_in <= pixel_in + 24'h01_0101;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // geometry: 4x2 active, h 2/1/1, v 1/1/1 -> 8 pixels a line, 5 lines a frame
  task automatic run_cfg(input logic [31:0] div, input logic [1:0] pol, input int half,
                         input logic inv, input logic [3:0] lag);
    mdl_rst_n <= 1'b0;
    wr(ttg_pkg::CONTROL_OFS, 32'h0000_0000);
    wr(ttg_pkg::CLOCK_DIVIDE_OFS, div);
    wr(ttg_pkg::SYNC_POLARITY_OFS, {30'h0, pol});
    m_pol <= pol;
    m_inv <= inv;
    m_lag <= lag;
    wr(ttg_pkg::CONTROL_OFS, 32'h0000_0001);
    mdl_rst_n <= 1'b1;
    repeat (3 * 5 * 8 * 2 * half) @(posedge clock);
    chk(pmin, 2 * half);
    chk(pmax, 2 * half);
    chk(pmin * ttg_pkg::CLOCK_PERIOD_PS >= ttg_pkg::PIXEL_PERIOD_MIN_PS, 1);
    chk(line_len, 8);
    chk(hs_w, 2);
    chk(de_ofs, 3);
    chk(de_cnt, 8);
    chk(frame_len, 5);
    chk(vs_w, 1);
    chk(errs, 0);
    rd(ttg_pkg::STATUS_OFS, rv);
    chk(rv[31], 1);
    wr(ttg_pkg::CONTROL_OFS, 32'h0000_0000);
    // long enough for the deepest clock delay tap to drain
    repeat (20) @(posedge clock);
    chk({line_sync, frame_sync}, {pol[0], pol[1]});
    chk({data_valid_strobe, line_data}, 25'h0);
    if (!inv) chk(pixel_clock, 0);
  endtask

  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // cut a hang short well beyond the expected run
  always @(posedge clock)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_count++;
      final_report;
    end
  end

  initial
  begin
    rst_tab = '{ttg_pkg::CONTROL_RST, ttg_pkg::CLOCK_DIVIDE_RST, ttg_pkg::SYNC_POLARITY_RST,
                ttg_pkg::DISPLAY_SIZE_RST, ttg_pkg::HORIZONTAL_TIMING_RST,
                ttg_pkg::VERTICAL_TIMING_RST};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(4 * i), rv);
      chk(rv, rst_tab[i]);
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, rv);
    chk(rv, 32'h0000_0000);
    wr(ttg_pkg::SYNC_POLARITY_OFS, 32'hFFFF_FFFF);
    rd(ttg_pkg::SYNC_POLARITY_OFS, rv);
    chk(rv, 32'h0000_0003);
    wr(ttg_pkg::DISPLAY_SIZE_OFS, 32'h0002_0004);
    wr(ttg_pkg::HORIZONTAL_TIMING_OFS, 32'h0010_0402);
    wr(ttg_pkg::VERTICAL_TIMING_OFS, 32'h0010_0401);
    rd(ttg_pkg::HORIZONTAL_TIMING_OFS, rv);
    chk(rv, 32'h0010_0402);
    // half period 1 is clamped to the fastest legal pixel clock
    run_cfg(32'h0000_0001, 2'h0, 2, 1'b0, 4'h0);
    run_cfg(32'h0000_1103, 2'h3, 3, 1'b1, 4'h1);
    // half period 255 is clamped to the slowest legal pixel clock
    run_cfg(32'h0000_20FF, 2'h1, 25, 1'b0, 4'h2);
    final_report;
  end
endmodule

`default_nettype wire

// File: ttg_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

module ttg_panel_model
(
  // system side
  input  wire logic        clock,
  input  wire logic        rst_n,
  // panel pins
  input  wire logic        pixel_clock,
  input  wire logic        line_sync,
  input  wire logic        frame_sync,
  input  wire logic        data_valid_strobe,
  input  wire logic [23:0] line_data,
  // pixel source watch
  input  wire logic        pixel_req,
  input  wire logic [23:0] pixel_in,
  // settings and results
  input  wire logic [1:0]  pol,
  input  wire logic        inv,
  input  wire logic [3:0]  lag,
  output int               pmin,
  output int               pmax,
  output int               line_len,
  output int               hs_w,
  output int               de_ofs,
  output int               de_cnt,
  output int               frame_len,
  output int               vs_w,
  output int               errs
);
  logic [26:0] prev;
  logic        eff_q, hs_q, vs_q, seen, pend;
  int          cyc, since, px, ln, hs_run, de_run, vs_run;
  logic [23:0] q[$];

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      {eff_q, hs_q, vs_q, seen, pend} = '0;
      {cyc, px, ln, hs_run, de_run, vs_run, errs} = '0;
      // stale results from an earlier run must not pass for fresh ones
      {line_len, hs_w, de_ofs, de_cnt, frame_len, vs_w} = '0;
      pmin = 1000;
      pmax = 0;
      q.delete();
    end
    else
    begin
      cyc++;
      // every output change must lead the panel's rising edge by lag
      if ({line_sync, frame_sync, data_valid_strobe, line_data} != prev)
      begin
        if (pend) errs++;
        pend = 1;
        since = 0;
      end
      else if (pend) since++;
      if (pixel_req) q.push_back(pixel_in);
      if ((pixel_clock ^ inv) && !eff_q)
      begin
        if (seen && cyc < pmin) pmin = cyc;
        if (seen && cyc > pmax) pmax = cyc;
        seen = 1;
        cyc = 0;
        if (pend && since != lag) errs++;
        pend = 0;
        if ((line_sync ^ pol[0]) && !hs_q)
        begin
          line_len = px;
          hs_w = hs_run;
          px = 0;
          hs_run = 0;
          if ((frame_sync ^ pol[1]) && !vs_q)
          begin
            frame_len = ln;
            vs_w = vs_run;
            de_cnt = de_run;
            {ln, vs_run, de_run} = '0;
            q.delete();
          end
          if (frame_sync ^ pol[1]) vs_run++;
          vs_q = frame_sync ^ pol[1];
          ln++;
        end
        hs_q = line_sync ^ pol[0];
        if (hs_q) hs_run++;
        if (data_valid_strobe)
        begin
          if (px < de_ofs || de_run == 0) de_ofs = px;
          de_run++;
          if (q.size() == 0) errs++;
          else if (line_data !== q.pop_front()) errs++;
        end
        else if (line_data !== 24'h00_0000) errs++;
        px++;
      end
      eff_q = pixel_clock ^ inv;
    end
    prev = {line_sync, frame_sync, data_valid_strobe, line_data};
  end
endmodule

`default_nettype wire

// File: ttg_pkg.sv
package ttg_pkg;

  // register port
  localparam int         ADDR_W = 8;
  localparam int         DATA_W = 32;

  // register offsets
  localparam logic [7:0] CONTROL_OFS           = 8'h00;
  localparam logic [7:0] CLOCK_DIVIDE_OFS      = 8'h04;
  localparam logic [7:0] SYNC_POLARITY_OFS     = 8'h08;
  localparam logic [7:0] DISPLAY_SIZE_OFS      = 8'h0C;
  localparam logic [7:0] HORIZONTAL_TIMING_OFS = 8'h10;
  localparam logic [7:0] VERTICAL_TIMING_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS            = 8'h18;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int DIV_HALF_LSB    = 0;
  localparam int DIV_HALF_W      = 8;
  localparam int DIV_INVERT_BIT  = 8;
  localparam int DIV_DELAY_LSB   = 12;
  localparam int DIV_DELAY_W     = 4;
  localparam int POL_LINE_BIT    = 0;
  localparam int POL_FRAME_BIT   = 1;
  localparam int SIZE_X_LSB      = 0;
  localparam int SIZE_Y_LSB      = 16;
  localparam int SIZE_W          = 12;
  localparam int TIM_SYNC_LSB    = 0;
  localparam int TIM_BACK_LSB    = 10;
  localparam int TIM_FRONT_LSB   = 20;
  localparam int TIM_W           = 10;
  localparam int STAT_X_LSB      = 0;
  localparam int STAT_Y_LSB      = 16;
  localparam int STAT_RUN_BIT    = 31;
  localparam int CNT_W           = 14;
  localparam int DELAY_TAPS      = 16;
  localparam int PIXEL_W         = 24;

  // writable bits; the rest read as zero
  localparam logic [31:0] CONTROL_MASK       = 32'h0000_0001;
  localparam logic [31:0] CLOCK_DIVIDE_MASK  = 32'h0000_F1FF;
  localparam logic [31:0] SYNC_POLARITY_MASK = 32'h0000_0003;
  localparam logic [31:0] DISPLAY_SIZE_MASK  = 32'h0FFF_0FFF;
  localparam logic [31:0] TIMING_MASK        = 32'h3FFF_FFFF;

  // reset values
  localparam logic [31:0] CONTROL_RST           = 32'h0000_0000;
  localparam logic [31:0] CLOCK_DIVIDE_RST      = 32'h0000_0005;
  localparam logic [31:0] SYNC_POLARITY_RST     = 32'h0000_0000;
  localparam logic [31:0] DISPLAY_SIZE_RST      = 32'h01E0_0280;
  localparam logic [31:0] HORIZONTAL_TIMING_RST = 32'h0100_C060;
  localparam logic [31:0] VERTICAL_TIMING_RST   = 32'h00A0_8402;

  // timing
  localparam int CLOCK_PERIOD_PS     = 4000;
  localparam int PIXEL_PERIOD_MIN_PS = 11200;
  localparam int PIXEL_FREQ_MIN_KHZ  = 5000;
  localparam int PIXEL_FREQ_MAX_KHZ  = 66000;
  localparam int PS_PER_KHZ          = 1000000000;
  localparam int HALF_MIN_BY_PERIOD  =
    (PIXEL_PERIOD_MIN_PS + 2 * CLOCK_PERIOD_PS - 1) / (2 * CLOCK_PERIOD_PS);
  localparam int HALF_MIN_BY_FREQ    =
    (PS_PER_KHZ / PIXEL_FREQ_MAX_KHZ + 2 * CLOCK_PERIOD_PS - 1) / (2 * CLOCK_PERIOD_PS);
  localparam int HALF_MIN = (HALF_MIN_BY_PERIOD > HALF_MIN_BY_FREQ) ?
                            HALF_MIN_BY_PERIOD : HALF_MIN_BY_FREQ;
  localparam int HALF_MAX = (PS_PER_KHZ / PIXEL_FREQ_MIN_KHZ) / (2 * CLOCK_PERIOD_PS);

  typedef enum logic {
    TTG_IDLE,
    TTG_RUN
  } ttg_run_t;

endpackage

// File: ttg_timing_gen.sv
// Operation
// R01 - panel samples data on rising pixel clock
// R02 - pixel clock runs continuously while active
// R03 - pixel clock programmable from 5 to 66 MHz
// R04 - line sync starts line, spans one pixel clock; here it spans the programmed sync width (reset 96, zero taken as one)
// R05 - frame sync starts frame, spans line sync
// R06 - data valid strobe marks valid line data
// R07 - outputs change only on rising pixel clock
// R08 - sync polarities selectable, default active high
// R09 - data valid strobe always active high
// R10 - pixel clock inversion and programmable delay
// R11 - geometry held in three software registers
// R12 - line is sync, porches and active pixels
// R13 - frame is sync, porches and active lines
// R14 - one line covers sync and pixel data
// R15 - pixel clock period at least 11.2 ns
// R16 - order: sync, back porch, active, front porch
// R17 - strobe only in active pixels of lines
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ttg_timing_gen
(
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  // register port
  input  wire logic [ttg_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ttg_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [ttg_pkg::DATA_W-1:0]   reg_rdata,
  // pixel source
  input  wire logic [ttg_pkg::PIXEL_W-1:0]  pixel_in,
  output logic                              pixel_req,
  // panel
  output logic                              pixel_clock,
  output logic                              line_sync,
  output logic                              frame_sync,
  output logic                              data_valid_strobe,
  output logic      [ttg_pkg::PIXEL_W-1:0]  line_data
);

  localparam int CW = ttg_pkg::CNT_W;

  logic [31:0]              control_reg;
  logic [31:0]              clock_divide_reg;
  logic [31:0]              sync_polarity_reg;
  logic [31:0]              display_size_reg;
  logic [31:0]              horizontal_timing_reg;
  logic [31:0]              vertical_timing_reg;
  logic [31:0]              next_control_reg;
  logic [31:0]              next_clock_divide_reg;
  logic [31:0]              next_sync_polarity_reg;
  logic [31:0]              next_display_size_reg;
  logic [31:0]              next_horizontal_timing_reg;
  logic [31:0]              next_vertical_timing_reg;
  logic [31:0]              next_reg_rdata;
  logic [31:0]              status_word;

  ttg_pkg::ttg_run_t        state;
  ttg_pkg::ttg_run_t        next_state;
  logic [7:0]               div_cnt;
  logic [7:0]               next_div_cnt;
  logic                     pclk_int;
  logic                     next_pclk_int;
  logic                     rise_en;
  logic [7:0]               half;
  logic [7:0]               half_raw;
  logic [ttg_pkg::DELAY_TAPS-1:0] taps;
  logic [3:0]               delay_sel;
  logic                     pclk_delayed;
  logic                     next_pixel_clock;

  logic [CW-1:0]            h_cnt;
  logic [CW-1:0]            v_cnt;
  logic [CW-1:0]            next_h_cnt;
  logic [CW-1:0]            next_v_cnt;
  logic [CW-1:0]            h_sync_end;
  logic [CW-1:0]            h_act_start;
  logic [CW-1:0]            h_act_end;
  logic [CW-1:0]            h_last;
  logic [CW-1:0]            v_sync_end;
  logic [CW-1:0]            v_act_start;
  logic [CW-1:0]            v_act_end;
  logic [CW-1:0]            v_last;
  logic [ttg_pkg::TIM_W-1:0] hsw;
  logic [ttg_pkg::TIM_W-1:0] vsw;
  logic                     hs_now;
  logic                     vs_now;
  logic                     de_now;
  logic                     hs_q;
  logic                     vs_q;
  logic                     next_hs_q;
  logic                     next_vs_q;
  logic                     next_line_sync;
  logic                     next_frame_sync;
  logic                     next_de;
  logic [ttg_pkg::PIXEL_W-1:0] next_line_data;
  logic                     pol_line;
  logic                     pol_frame;

  // register file
  always_comb
  begin
    next_control_reg           = control_reg;
    next_clock_divide_reg      = clock_divide_reg;
    next_sync_polarity_reg     = sync_polarity_reg;
    next_display_size_reg      = display_size_reg;
    next_horizontal_timing_reg = horizontal_timing_reg;
    next_vertical_timing_reg   = vertical_timing_reg;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ttg_pkg::CONTROL_OFS:
          next_control_reg = reg_wdata & ttg_pkg::CONTROL_MASK;
        ttg_pkg::CLOCK_DIVIDE_OFS:
          next_clock_divide_reg = reg_wdata & ttg_pkg::CLOCK_DIVIDE_MASK; // [R03] [R10]
        ttg_pkg::SYNC_POLARITY_OFS:
          next_sync_polarity_reg = reg_wdata & ttg_pkg::SYNC_POLARITY_MASK; // [R08]
        ttg_pkg::DISPLAY_SIZE_OFS:
          next_display_size_reg = reg_wdata & ttg_pkg::DISPLAY_SIZE_MASK; // [R11]
        ttg_pkg::HORIZONTAL_TIMING_OFS:
          next_horizontal_timing_reg = reg_wdata & ttg_pkg::TIMING_MASK; // [R11]
        ttg_pkg::VERTICAL_TIMING_OFS:
          next_vertical_timing_reg = reg_wdata & ttg_pkg::TIMING_MASK; // [R11]
        default:
        begin
        end
      endcase
    end
    status_word = 32'h0000_0000;
    status_word[ttg_pkg::STAT_X_LSB +: CW] = h_cnt;
    status_word[ttg_pkg::STAT_Y_LSB +: CW] = v_cnt;
    status_word[ttg_pkg::STAT_RUN_BIT]     = (state == ttg_pkg::TTG_RUN);
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ttg_pkg::CONTROL_OFS:           next_reg_rdata = control_reg;
        ttg_pkg::CLOCK_DIVIDE_OFS:      next_reg_rdata = clock_divide_reg;
        ttg_pkg::SYNC_POLARITY_OFS:     next_reg_rdata = sync_polarity_reg;
        ttg_pkg::DISPLAY_SIZE_OFS:      next_reg_rdata = display_size_reg;
        ttg_pkg::HORIZONTAL_TIMING_OFS: next_reg_rdata = horizontal_timing_reg;
        ttg_pkg::VERTICAL_TIMING_OFS:   next_reg_rdata = vertical_timing_reg;
        ttg_pkg::STATUS_OFS:            next_reg_rdata = status_word;
        default:                        next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      control_reg           <= ttg_pkg::CONTROL_RST;
      clock_divide_reg      <= ttg_pkg::CLOCK_DIVIDE_RST;
      sync_polarity_reg     <= ttg_pkg::SYNC_POLARITY_RST; // [R08]
      display_size_reg      <= ttg_pkg::DISPLAY_SIZE_RST;
      horizontal_timing_reg <= ttg_pkg::HORIZONTAL_TIMING_RST;
      vertical_timing_reg   <= ttg_pkg::VERTICAL_TIMING_RST;
      reg_rdata             <= 32'h0000_0000;
    end
    else
    begin
      control_reg           <= next_control_reg;
      clock_divide_reg      <= next_clock_divide_reg;
      sync_polarity_reg     <= next_sync_polarity_reg;
      display_size_reg      <= next_display_size_reg;
      horizontal_timing_reg <= next_horizontal_timing_reg;
      vertical_timing_reg   <= next_vertical_timing_reg;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // geometry; a zero sync width would lose the pulse, so it counts as one
  always_comb
  begin
    hsw = horizontal_timing_reg[ttg_pkg::TIM_SYNC_LSB +: ttg_pkg::TIM_W];
    vsw = vertical_timing_reg[ttg_pkg::TIM_SYNC_LSB +: ttg_pkg::TIM_W];
    if (hsw == '0)
      hsw = 10'h001; // [R04]
    if (vsw == '0)
      vsw = 10'h001; // [R05]
    // sync, back porch, active, front porch [R12] [R14] [R16]
    h_sync_end  = CW'(hsw);
    h_act_start = h_sync_end
                + CW'(horizontal_timing_reg[ttg_pkg::TIM_BACK_LSB +: ttg_pkg::TIM_W]);
    h_act_end   = h_act_start
                + CW'(display_size_reg[ttg_pkg::SIZE_X_LSB +: ttg_pkg::SIZE_W]);
    h_last      = h_act_end
                + CW'(horizontal_timing_reg[ttg_pkg::TIM_FRONT_LSB +: ttg_pkg::TIM_W])
                - CW'(1);
    // same order in line units [R13] [R16]
    v_sync_end  = CW'(vsw);
    v_act_start = v_sync_end
                + CW'(vertical_timing_reg[ttg_pkg::TIM_BACK_LSB +: ttg_pkg::TIM_W]);
    v_act_end   = v_act_start
                + CW'(display_size_reg[ttg_pkg::SIZE_Y_LSB +: ttg_pkg::SIZE_W]);
    v_last      = v_act_end
                + CW'(vertical_timing_reg[ttg_pkg::TIM_FRONT_LSB +: ttg_pkg::TIM_W])
                - CW'(1);
  end

  // pixel clock divider; half period clamped so 11.2 ns and 5..66 MHz hold
  always_comb
  begin
    half_raw = clock_divide_reg[ttg_pkg::DIV_HALF_LSB +: ttg_pkg::DIV_HALF_W];
    if (half_raw < 8'(ttg_pkg::HALF_MIN))
      half = 8'(ttg_pkg::HALF_MIN); // [R15] [R03]
    else if (half_raw > 8'(ttg_pkg::HALF_MAX))
      half = 8'(ttg_pkg::HALF_MAX); // [R03]
    else
      half = half_raw;
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_pclk_int = pclk_int;
    rise_en       = 1'b0;
    unique case (state)
      ttg_pkg::TTG_IDLE:
      begin
        next_div_cnt  = 8'h00;
        next_pclk_int = 1'b0;
        if (control_reg[ttg_pkg::CTRL_ENABLE_BIT])
          next_state = ttg_pkg::TTG_RUN;
      end
      ttg_pkg::TTG_RUN:
      begin
        if (!control_reg[ttg_pkg::CTRL_ENABLE_BIT])
        begin
          next_state    = ttg_pkg::TTG_IDLE;
          next_div_cnt  = 8'h00;
          next_pclk_int = 1'b0;
        end
        else if (div_cnt >= half - 8'h01)
        begin
          // free running: no gating at line or frame boundaries
          next_div_cnt  = 8'h00;
          next_pclk_int = !pclk_int; // [R02]
          rise_en       = !pclk_int;
        end
        else
          next_div_cnt = div_cnt + 8'h01;
      end
    endcase
  end

  // output clock: delay taps then optional inversion
  // delay 0 puts the rise on the same edge that moves the data; tap n lags by n
  always_comb
  begin
    delay_sel = clock_divide_reg[ttg_pkg::DIV_DELAY_LSB +: ttg_pkg::DIV_DELAY_W];
    if (delay_sel == 4'h0)
      pclk_delayed = next_pclk_int; // [R07]
    else
      pclk_delayed = taps[delay_sel - 4'h1]; // [R10]
    next_pixel_clock = pclk_delayed ^ clock_divide_reg[ttg_pkg::DIV_INVERT_BIT]; // [R10]
  end

  // raster counters and panel outputs
  always_comb
  begin
    pol_line  = sync_polarity_reg[ttg_pkg::POL_LINE_BIT];
    pol_frame = sync_polarity_reg[ttg_pkg::POL_FRAME_BIT];
    hs_now = (h_cnt < h_sync_end); // [R04]
    vs_now = (v_cnt < v_sync_end); // [R05]
    de_now = (h_cnt >= h_act_start) && (h_cnt < h_act_end)
          && (v_cnt >= v_act_start) && (v_cnt < v_act_end); // [R17]
    next_h_cnt      = h_cnt;
    next_v_cnt      = v_cnt;
    next_hs_q       = hs_q;
    next_vs_q       = vs_q;
    next_line_sync  = line_sync;
    next_frame_sync = frame_sync;
    next_de         = data_valid_strobe;
    next_line_data  = line_data;
    pixel_req       = 1'b0;
    if (state != ttg_pkg::TTG_RUN)
    begin
      next_h_cnt      = '0;
      next_v_cnt      = '0;
      next_hs_q       = 1'b0;
      next_vs_q       = 1'b0;
      next_line_sync  = pol_line;
      next_frame_sync = pol_frame;
      next_de         = 1'b0;
      next_line_data  = '0;
    end
    else if (rise_en)
    begin
      // outputs move together with the rising pixel clock [R07]
      next_hs_q       = hs_now;
      next_vs_q       = vs_now;
      next_line_sync  = hs_now ^ pol_line;  // [R08]
      next_frame_sync = vs_now ^ pol_frame; // [R08]
      next_de         = de_now;             // [R09]
      next_line_data  = de_now ? pixel_in : '0; // [R06]
      pixel_req       = de_now;
      if (h_cnt >= h_last)
      begin
        next_h_cnt = '0;
        next_v_cnt = (v_cnt >= v_last) ? '0 : v_cnt + CW'(1); // [R13]
      end
      else
        next_h_cnt = h_cnt + CW'(1); // [R12]
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state             <= ttg_pkg::TTG_IDLE;
      div_cnt           <= 8'h00;
      pclk_int          <= 1'b0;
      taps              <= '0;
      pixel_clock       <= 1'b0;
      h_cnt             <= '0;
      v_cnt             <= '0;
      hs_q              <= 1'b0;
      vs_q              <= 1'b0;
      line_sync         <= 1'b0;
      frame_sync        <= 1'b0;
      data_valid_strobe <= 1'b0;
      line_data         <= '0;
    end
    else
    begin
      state             <= next_state;
      div_cnt           <= next_div_cnt;
      pclk_int          <= next_pclk_int;
      taps              <= {taps[ttg_pkg::DELAY_TAPS-2:0], next_pclk_int};
      pixel_clock       <= next_pixel_clock;
      h_cnt             <= next_h_cnt;
      v_cnt             <= next_v_cnt;
      hs_q              <= next_hs_q;
      vs_q              <= next_vs_q;
      line_sync         <= next_line_sync;
      frame_sync        <= next_frame_sync;
      data_valid_strobe <= next_de;
      line_data         <= next_line_data;
    end
  end

  // checks
  logic [7:0] stable_cnt;
  always_ff @(posedge clock)
  begin
    if (!rst_n || state != ttg_pkg::TTG_RUN || next_pclk_int != pclk_int)
      stable_cnt <= 8'h00;
    else
      stable_cnt <= stable_cnt + 8'h01;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_clock_runs;
    (state == ttg_pkg::TTG_RUN) |-> (stable_cnt < 8'(ttg_pkg::HALF_MAX));
  endproperty
  a_clock_runs: assert property (p_clock_runs) // [R02]
    else $error("pixel clock stalled while running");

  property p_half_min;
    (state == ttg_pkg::TTG_RUN) && $changed(pclk_int) ##1 (state == ttg_pkg::TTG_RUN)
      |-> $stable(pclk_int);
  endproperty
  a_half_min: assert property (p_half_min) // [R15]
    else $error("pixel clock half period below minimum");

  property p_out_on_rise;
    (state == ttg_pkg::TTG_RUN) && !rise_en ##1 (state == ttg_pkg::TTG_RUN)
      |-> $stable(line_data) && $stable(hs_q) && $stable(vs_q) && $stable(data_valid_strobe)
          && $stable(line_sync) && $stable(frame_sync);
  endproperty
  a_out_on_rise: assert property (p_out_on_rise) // [R07]
    else $error("panel output changed off the pixel clock rise");

  property p_line_sync_width;
    // a disable may cut the pulse short; that is legal
    $rose(hs_q) |-> (hs_q || state != ttg_pkg::TTG_RUN) [*4];
  endproperty
  a_line_sync_width: assert property (p_line_sync_width) // [R04]
    else $error("line sync shorter than one pixel clock");

  property p_frame_covers;
    ($rose(vs_q) || $fell(vs_q)) |-> (hs_q || state != ttg_pkg::TTG_RUN);
  endproperty
  a_frame_covers: assert property (p_frame_covers) // [R05]
    else $error("frame sync edge not at line start");

  property p_blank_data;
    !data_valid_strobe |-> (line_data == '0);
  endproperty
  a_blank_data: assert property (p_blank_data) // [R06]
    else $error("line data not blank while strobe low");

  property p_strobe_off_sync;
    data_valid_strobe |-> !hs_q && !vs_q;
  endproperty
  a_strobe_off_sync: assert property (p_strobe_off_sync) // [R17]
    else $error("strobe high during sync");

  property p_line_wrap;
    rise_en && (state == ttg_pkg::TTG_RUN) && control_reg[ttg_pkg::CTRL_ENABLE_BIT]
      |=> (h_cnt == (($past(h_cnt) >= $past(h_last)) ? '0 : $past(h_cnt) + CW'(1)));
  endproperty
  a_line_wrap: assert property (p_line_wrap) // [R12]
    else $error("line counter did not follow line period");

  property p_frame_wrap;
    rise_en && (h_cnt >= h_last) && control_reg[ttg_pkg::CTRL_ENABLE_BIT]
      |=> (v_cnt == (($past(v_cnt) >= $past(v_last)) ? '0 : $past(v_cnt) + CW'(1)));
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) // [R13]
    else $error("frame counter did not follow frame period");

endmodule

`default_nettype wire
